// ==== common/dscg_regs.vh ====
// Register map and field layout of the deep-sleep clock gating bank
`ifndef DSCG_REGS_VH
`define DSCG_REGS_VH

// Register byte offsets
`define DSCG_DS_GATE_OFS 12'h124
`define DSCG_CTRL_OFS 12'h200
`define DSCG_RUN_GATE_OFS 12'h204
`define DSCG_INT_STATUS_OFS 12'h208
`define DSCG_INT_ENABLE_OFS 12'h20c
`define DSCG_INT_CLEAR_OFS 12'h210

// Reset values
`define DSCG_DS_GATE_RST 32'h00000000
`define DSCG_RUN_GATE_RST 32'h00000000
`define DSCG_CTRL_RST 1'h0
`define DSCG_INT_RST 3'h0

// Writable bits of both gating registers
`define DSCG_GATE_MASK 32'h07071013

// Gating field positions
`define DSCG_COMPARATOR_TWO_GATE_BIT 26
`define DSCG_COMPARATOR_ONE_GATE_BIT 25
`define DSCG_COMPARATOR_ZERO_GATE_BIT 24
`define DSCG_TIMER_TWO_GATE_BIT 18
`define DSCG_TIMER_ONE_GATE_BIT 17
`define DSCG_TIMER_ZERO_GATE_BIT 16
`define DSCG_TWI_BIT 12
`define DSCG_SSU_BIT 4
`define DSCG_SER1_BIT 1
`define DSCG_SER0_BIT 0

// Packed unit index, used on the unit access port
`define DSCG_UNITS 10
`define DSCG_IDX_W 4
`define DSCG_U_SER0 4'h0
`define DSCG_U_SER1 4'h1
`define DSCG_U_SSU 4'h2
`define DSCG_U_TWI 4'h3
`define DSCG_U_TIMER_ZERO_GATE 4'h4
`define DSCG_U_TIMER_ONE_GATE 4'h5
`define DSCG_U_TIMER_TWO_GATE 4'h6
`define DSCG_U_COMPARATOR_ZERO_GATE 4'h7
`define DSCG_U_COMPARATOR_ONE_GATE 4'h8
`define DSCG_U_COMPARATOR_TWO_GATE 4'h9

// Control register: automatic gating enable
`define DSCG_CTRL_AUTO_BIT 0

// Interrupt status bits
`define DSCG_INT_W 3
`define DSCG_INT_FAULT_BIT 0
`define DSCG_INT_ENTER_BIT 1
`define DSCG_INT_EXIT_BIT 2

`endif

// ==== hdl/dscg_clock_gate_bank.v ====
// Deep-sleep peripheral clock gating bank with APB register access
// Function
// - Unit clocked and enabled only while bit set
// - Access to gated-off unit returns bus fault
// - All gating bits reset to zero
// - Deep-sleep gating applies only with automatic gating
// - Gating register decoded at offset 0x124, read/write
// - Bits 18,17,16 enable timers two,one,zero
// - Bit 12 enables the two-wire unit
// - Bit 4 enables the synchronous serial unit
// - Bit 1 second serial port, bit 0 first
// - Reserved bits read zero, ignore writes
// - Bits 26,25,24 enable comparators two,one,zero
`timescale 1ns/100ps
`default_nettype none
`include "dscg_regs.vh"

module dscg_clock_gate_bank #(
    parameter ADDR_W = 12,
    parameter UNITS = `DSCG_UNITS,
    parameter IDX_W = `DSCG_IDX_W
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Power mode from the power controller
    input wire deepSleep,
    // Peripheral access check
    input wire unitReq,
    input wire [IDX_W-1:0] unitIdx,
    output reg unitFault,
    output reg unitGrant,
    // Unit clock enables and enables
    output reg [UNITS-1:0] unitClkEn,
    // Interrupt
    output wire irq
);

    // Gating register bit positions, indexed by packed unit number
    function integer gateBitPos;
        input integer u;
        begin
            case (u)
                0: gateBitPos = `DSCG_SER0_BIT;
                1: gateBitPos = `DSCG_SER1_BIT;
                2: gateBitPos = `DSCG_SSU_BIT;
                3: gateBitPos = `DSCG_TWI_BIT;
                4: gateBitPos = `DSCG_TIMER_ZERO_GATE_BIT;
                5: gateBitPos = `DSCG_TIMER_ONE_GATE_BIT;
                6: gateBitPos = `DSCG_TIMER_TWO_GATE_BIT;
                7: gateBitPos = `DSCG_COMPARATOR_ZERO_GATE_BIT;
                8: gateBitPos = `DSCG_COMPARATOR_ONE_GATE_BIT;
                default: gateBitPos = `DSCG_COMPARATOR_TWO_GATE_BIT;
            endcase
        end
    endfunction

    // Pack a 32-bit gating register into one bit per unit
    function [UNITS-1:0] packGate;
        input [31:0] regVal;
        integer k;
        begin
            packGate = {UNITS{1'b0}};
            for (k = 0; k < UNITS; k = k + 1) begin
                packGate[k] = regVal[gateBitPos(k)];
            end
        end
    endfunction

    // Byte-lane merge, then reserved bits forced to zero
    function [31:0] mergeGate;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0] strb;
        integer b;
        begin
            mergeGate = oldVal;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    mergeGate[b*8 +: 8] = newVal[b*8 +: 8];
                end
            end
            mergeGate = mergeGate & `DSCG_GATE_MASK;
        end
    endfunction

    // One-hot register select, shared by read and write decode
    localparam SEL_W = 6;
    localparam SEL_DS = 0;
    localparam SEL_CTRL = 1;
    localparam SEL_RUN = 2;
    localparam SEL_STAT = 3;
    localparam SEL_EN = 4;
    localparam SEL_CLR = 5;

    function [SEL_W-1:0] regSelect;
        input [ADDR_W-1:0] addr;
        begin
            regSelect = {SEL_W{1'b0}};
            if (addr == `DSCG_DS_GATE_OFS) begin
                regSelect[SEL_DS] = 1'b1;
            end else if (addr == `DSCG_CTRL_OFS) begin
                regSelect[SEL_CTRL] = 1'b1;
            end else if (addr == `DSCG_RUN_GATE_OFS) begin
                regSelect[SEL_RUN] = 1'b1;
            end else if (addr == `DSCG_INT_STATUS_OFS) begin
                regSelect[SEL_STAT] = 1'b1;
            end else if (addr == `DSCG_INT_ENABLE_OFS) begin
                regSelect[SEL_EN] = 1'b1;
            end else if (addr == `DSCG_INT_CLEAR_OFS) begin
                regSelect[SEL_CLR] = 1'b1;
            end
        end
    endfunction

    // Register state
    reg [31:0] dsGate_r;
    reg [31:0] dsGate_nxt;
    reg [31:0] runGate_r;
    reg [31:0] runGate_nxt;
    reg autoGate_r;
    reg autoGate_nxt;
    reg [`DSCG_INT_W-1:0] intStatus_r;
    reg [`DSCG_INT_W-1:0] intStatus_nxt;
    reg [`DSCG_INT_W-1:0] intEnable_r;
    reg [`DSCG_INT_W-1:0] intEnable_nxt;
    reg deepSleep_r;

    // Bus decode
    reg [31:0] rdMux;
    reg addrHit;
    reg [`DSCG_INT_W-1:0] intClear;
    wire setupPhase;
    wire wrAccess;
    wire [SEL_W-1:0] regSel;
    wire [31:0] rdData;

    // Per-register write strobes, only in the access cycle
    wire wrDsGate;
    wire wrCtrl;
    wire wrRunGate;
    wire wrIntEnable;
    wire wrIntClear;

    // Gate selection outputs
    wire [UNITS-1:0] runGatePk;
    wire [UNITS-1:0] dsGatePk;
    wire [UNITS-1:0] effGate;
    wire accFault;
    wire accOk;

    // Events
    wire dsEnter;
    wire dsLeave;
    wire [`DSCG_INT_W-1:0] intEvent;

    // Zero wait states: read data and error are staged in the setup cycle
    assign pready = 1'b1;
    assign setupPhase = psel & ~penable;
    assign wrAccess = psel & penable & pwrite;
    assign regSel = regSelect(paddr);

    // Status register has no strobe: software cannot set its bits
    assign wrDsGate = wrAccess & regSel[SEL_DS];
    assign wrCtrl = wrAccess & regSel[SEL_CTRL];
    assign wrRunGate = wrAccess & regSel[SEL_RUN];
    assign wrIntEnable = wrAccess & regSel[SEL_EN];
    assign wrIntClear = wrAccess & regSel[SEL_CLR];

    // Writes return zero so a stale register value never leaks
    assign rdData = pwrite ? 32'h00000000 : rdMux;

    // Read mux and address decode
    always @* begin
        rdMux = 32'h00000000;
        addrHit = 1'b1;
        if (regSel[SEL_DS]) begin
            rdMux = dsGate_r;
        end else if (regSel[SEL_CTRL]) begin
            rdMux[`DSCG_CTRL_AUTO_BIT] = autoGate_r;
        end else if (regSel[SEL_RUN]) begin
            rdMux = runGate_r;
        end else if (regSel[SEL_STAT]) begin
            rdMux[`DSCG_INT_W-1:0] = intStatus_r;
        end else if (regSel[SEL_EN]) begin
            rdMux[`DSCG_INT_W-1:0] = intEnable_r;
        end else if (regSel[SEL_CLR]) begin
            rdMux = 32'h00000000;
        end else begin
            addrHit = 1'b0;
        end
    end

    // Register writes, taken on the access edge only
    always @* begin
        dsGate_nxt = dsGate_r;
        runGate_nxt = runGate_r;
        autoGate_nxt = autoGate_r;
        intEnable_nxt = intEnable_r;
        intClear = {`DSCG_INT_W{1'b0}};
        if (wrDsGate) begin
            dsGate_nxt = mergeGate(dsGate_r, pwdata, pstrb);
        end
        if (wrRunGate) begin
            runGate_nxt = mergeGate(runGate_r, pwdata, pstrb);
        end
        if (wrCtrl & pstrb[0]) begin
            autoGate_nxt = pwdata[`DSCG_CTRL_AUTO_BIT];
        end
        if (wrIntEnable & pstrb[0]) begin
            intEnable_nxt = pwdata[`DSCG_INT_W-1:0];
        end
        if (wrIntClear & pstrb[0]) begin
            intClear = pwdata[`DSCG_INT_W-1:0];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    assign dsEnter = deepSleep & ~deepSleep_r;
    assign dsLeave = ~deepSleep & deepSleep_r;
    assign intEvent[`DSCG_INT_FAULT_BIT] = accFault;
    assign intEvent[`DSCG_INT_ENTER_BIT] = dsEnter;
    assign intEvent[`DSCG_INT_EXIT_BIT] = dsLeave;

    always @* begin
        intStatus_nxt = (intStatus_r & ~intClear) | intEvent;
    end

    assign irq = |(intStatus_r & intEnable_r);

    // Packed one bit per unit, in unit index order
    assign runGatePk = packGate(runGate_r);
    assign dsGatePk = packGate(dsGate_r);

    // Effective gating and fault check
    dscg_gate_select #(
        .UNITS(UNITS),
        .IDX_W(IDX_W)
    ) u_select (
        .deepSleep(deepSleep),
        .autoGate(autoGate_r),
        .runGate(runGatePk),
        .dsGate(dsGatePk),
        .accReq(unitReq),
        .accIdx(unitIdx),
        .effGate(effGate),
        .accFault(accFault),
        .accOk(accOk)
    );

    // Control and configuration registers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dsGate_r <= `DSCG_DS_GATE_RST;
            runGate_r <= `DSCG_RUN_GATE_RST;
            autoGate_r <= `DSCG_CTRL_RST;
            intEnable_r <= `DSCG_INT_RST;
            intStatus_r <= `DSCG_INT_RST;
            deepSleep_r <= 1'b0;
        end else begin
            dsGate_r <= dsGate_nxt;
            runGate_r <= runGate_nxt;
            autoGate_r <= autoGate_nxt;
            intEnable_r <= intEnable_nxt;
            intStatus_r <= intStatus_nxt;
            deepSleep_r <= deepSleep;
        end
    end

    // APB answer staged in setup so it is stable across the access phase
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= rdData;
            pslverr <= ~addrHit;
        end
    end

    // Registered enables feed glitch-free clock gate cells in each unit
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unitClkEn <= {UNITS{1'b0}};
        end else begin
            unitClkEn <= effGate;
        end
    end

    // Access answer one cycle after the request
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unitFault <= 1'b0;
            unitGrant <= 1'b0;
        end else begin
            unitFault <= accFault;
            unitGrant <= accOk;
        end
    end

endmodule // dscg_clock_gate_bank

`default_nettype wire

// ==== hdl/dscg_gate_select.v ====
// Effective gate selection and gated-unit fault check
`timescale 1ns/100ps
`default_nettype none
`include "dscg_regs.vh"

module dscg_gate_select #(
    parameter UNITS = `DSCG_UNITS,
    parameter IDX_W = `DSCG_IDX_W
) (
    // Mode
    input wire deepSleep,
    input wire autoGate,
    // Gating settings
    input wire [UNITS-1:0] runGate,
    input wire [UNITS-1:0] dsGate,
    // Unit access
    input wire accReq,
    input wire [IDX_W-1:0] accIdx,
    // Results
    output wire [UNITS-1:0] effGate,
    output wire accFault,
    output wire accOk
);

    wire useDeep;
    wire idxValid;
    wire unitOn;

    // Deep-sleep bank only counts with automatic gating on
    assign useDeep = deepSleep & autoGate;
    assign effGate = useDeep ? dsGate : runGate;

    // Indices beyond the last unit hit nothing and are ignored
    assign idxValid = (accIdx < UNITS);
    assign unitOn = idxValid ? effGate[accIdx] : 1'b0;

    assign accFault = accReq & idxValid & ~unitOn;
    assign accOk = accReq & idxValid & unitOn;

endmodule // dscg_gate_select

`default_nettype wire

// ==== verification/dscg_assertions.sv ====
// Checker for the deep-sleep clock gating bank
`timescale 1ns/100ps
`default_nettype none
module dscg_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Units
    input wire logic unitReq,
    input wire logic [3:0] unitIdx,
    input wire logic unitFault,
    input wire logic unitGrant,
    input wire logic [9:0] unitClkEn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_one_answer: assert property (unitReq && unitIdx < 4'ha |=>
        unitFault ^ unitGrant) else $error("Not one unit answer");
    chk_bad_quiet: assert property (unitReq && unitIdx > 4'h9 |=>
        !unitFault && !unitGrant) else $error("Answer to bad index");
    chk_idle_quiet: assert property (!unitReq |=>
        !unitFault && !unitGrant) else $error("Answer without request");
    chk_grant_clk: assert property (unitReq && unitIdx < 4'ha |=>
        unitGrant == unitClkEn[$past(unitIdx)]) else $error("Grant mismatch");
    chk_reset_zero: assert property ($fell(rst) |->
        unitClkEn == 10'h0 && prdata == 32'h0) else $error("Reset not zero");
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_gate_ok: assert property (psel && penable && paddr == 12'h124
        |-> !pslverr) else $error("Error on gating register");
    chk_unmap_err: assert property (psel && penable && paddr > 12'h210
        |-> pslverr) else $error("No error on unmapped");
    chk_resv_zero: assert property (psel && penable && paddr == 12'h124
        |-> (prdata & 32'hf8f8efec) == 32'h0) else $error("Reserved not 0");
    cover property (unitReq ##1 unitFault);
    cover property (unitReq ##1 unitGrant);
    cover property (psel && penable && pslverr);
endmodule // dscg_chk
bind dscg_clock_gate_bank dscg_chk i_chk (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .unitReq(unitReq),
    .unitIdx(unitIdx), .unitFault(unitFault), .unitGrant(unitGrant),
    .unitClkEn(unitClkEn));
`default_nettype wire

// ==== verification/dscg_tb.sv ====
// Testbench for the deep-sleep clock gating bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {logic [11:0] a; logic [31:0] d, e; logic er;} dscg_row_t;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    logic [3:0] pstrb = 0, unitIdx = 0, strb = 4'hf;
    logic deepSleep = 0, unitReq = 0, e, f, g, pready, pslverr;
    logic unitFault, unitGrant, irq;
    logic [31:0] prdata;
    logic [9:0] unitClkEn;
    int error_cnt = 0, checks_done = 0;
    int bp[10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
    dscg_row_t rows[6] = '{'{12'h124, 32'hffffffff, 32'h07071013, 0},
        '{12'h124, 32'hf8f8efec, 0, 0}, '{12'h204, 32'hffffffff,
        32'h07071013, 0}, '{12'h200, 32'hffffffff, 1, 0},
        '{12'h20c, 0, 0, 0}, '{12'h300, 5, 0, 1}};
    dscg_clock_gate_bank i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .deepSleep(deepSleep), .unitReq(unitReq), .unitIdx(unitIdx),
        .unitFault(unitFault), .unitGrant(unitGrant),
        .unitClkEn(unitClkEn), .irq(irq));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= strb;
        @(posedge sys_clk);
        penable <= 1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task ureq(input int k);
        @(posedge sys_clk);
        unitReq <= 1;
        unitIdx <= 4'(k);
        @(posedge sys_clk);
        unitReq <= 0;
        @(negedge sys_clk);
        f = unitFault;
        g = unitGrant;
    endtask
    task wt;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task close_out;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200us;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        apb(12'h124, 0, 0);
        chk(q, 0, "Gating reset value");
        foreach (rows[i]) begin
            apb(rows[i].a, 1, rows[i].d);
            apb(rows[i].a, 0, 0);
            chk(q, rows[i].e, "Register readback");
            chk({31'h0, e}, {31'h0, rows[i].er}, "Error flag");
        end
        $display("Register table done");
        apb(12'h200, 1, 0);
        apb(12'h124, 1, 0);
        // Only one bit is ever on, so the neighbour index must fault
        for (int k = 0; k < 10; k++) begin
            apb(12'h204, 1, 32'h1 << bp[k]);
            wt;
            chk({22'h0, unitClkEn}, 32'h1 << k, "Unit bit");
            ureq(k);
            chk({30'h0, f, g}, 1, "Clocked unit");
            ureq((k + 1) % 10);
            chk({30'h0, f, g}, 2, "Gated unit");
        end
        ureq(12);
        chk({30'h0, f, g}, 0, "Bad index");
        $display("Unit gating done");
        apb(12'h204, 1, 1);
        apb(12'h124, 1, 2);
        deepSleep <= 1;
        wt;
        chk({22'h0, unitClkEn}, 1, "No auto gating");
        apb(12'h200, 1, 1);
        wt;
        chk({22'h0, unitClkEn}, 2, "Auto gating");
        ureq(0);
        chk({30'h0, f, g}, 2, "Deep gated fault");
        deepSleep <= 0;
        wt;
        chk({22'h0, unitClkEn}, 1, "Back to run");
        $display("Deep-sleep done");
        chk({31'h0, irq}, 0, "Masked irq");
        apb(12'h208, 0, 0);
        chk(q, 7, "Status bits");
        apb(12'h20c, 1, 1);
        wt;
        chk({31'h0, irq}, 1, "Irq raised");
        apb(12'h210, 1, 7);
        wt;
        chk({31'h0, irq}, 0, "Irq cleared");
        apb(12'h208, 0, 0);
        chk(q, 0, "Status cleared");
        apb(12'h208, 1, 7);
        chk({31'h0, e}, 0, "Status write error");
        apb(12'h208, 0, 0);
        chk(q, 0, "Status read-only");
        $display("Interrupt done");
        ureq(1);
        chk({30'h0, f, g}, 2, "Fault before reset");
        chk({31'h0, irq}, 1, "Irq before reset");
        strb = 4'h4;
        apb(12'h124, 1, 32'hffffffff);
        strb = 4'hf;
        apb(12'h124, 0, 0);
        chk(q, 32'h00070002, "Lane 2 write");
        $display("Byte lanes done");
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        @(negedge sys_clk);
        chk({22'h0, unitClkEn}, 0, "Reset enables");
        chk({31'h0, irq}, 0, "Reset irq");
        apb(12'h124, 0, 0);
        chk(q, 0, "Reset gating");
        apb(12'h200, 0, 0);
        chk(q, 0, "Reset auto gating");
        $display("Mid-run reset done");
        close_out;
    end
endmodule // tb
`default_nettype wire
